// file: hw/replay_event_pkg.sv
// constants shared by the memory replay event selection block
package replay_event_pkg;

	// ----------------------------------------
	// widths and counts
	// ----------------------------------------
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned ADDR_W  = 12;
	localparam int unsigned CAUSE_W = 16;
	localparam int unsigned CODE_W  = 7;
	localparam int unsigned CSEL_W  = 3;
	localparam int unsigned NUM_SEL = 8;
	localparam int unsigned NUM_CNT = 8;
	localparam int unsigned IDX_W   = 3;

	// ----------------------------------------
	// select control and counter config fields
	// ----------------------------------------
	localparam int unsigned CODE_HI     = 31;
	localparam int unsigned CODE_LO     = 25;
	localparam int unsigned MASK_HI     = 24;
	localparam int unsigned MASK_LO     = 9;
	localparam int unsigned CFG_SEL_HI  = 15;
	localparam int unsigned CFG_SEL_LO  = 13;
	localparam int unsigned CFG_EN_BIT  = 12;
	localparam int unsigned CFG_RET_BIT = 11;

	localparam logic [DATA_W-1:0] SEL_RST       = 32'h0000_0000;
	localparam logic [DATA_W-1:0] CFG_RST       = 32'h0000_0000;
	localparam logic [DATA_W-1:0] SEL_READ_MASK = 32'hFFFF_FE00;
	localparam logic [DATA_W-1:0] CFG_READ_MASK = 32'h0000_F800;

	// ----------------------------------------
	// event select codes and counter config selects
	// ----------------------------------------
	localparam logic [CODE_W-1:0] CODE_WALK         = 7'h01;
	localparam logic [CODE_W-1:0] CODE_ORDER_REPLAY = 7'h03;
	localparam logic [CODE_W-1:0] CODE_LOAD_REPLAY  = 7'h04;
	localparam logic [CODE_W-1:0] CODE_STORE_REPLAY = 7'h05;
	localparam logic [CODE_W-1:0] CODE_BUS_REF      = 7'h0C;

	localparam logic [CSEL_W-1:0] CSEL_SPLIT = 3'h2;
	localparam logic [CSEL_W-1:0] CSEL_ORDER = 3'h2;
	localparam logic [CSEL_W-1:0] CSEL_WALK  = 3'h4;
	localparam logic [CSEL_W-1:0] CSEL_BUS   = 3'h7;

	// ----------------------------------------
	// cause mask bit positions
	// ----------------------------------------
	localparam int unsigned SPLIT_BIT      = 1;
	localparam int unsigned NO_ADDR_BIT    = 1;
	localparam int unsigned NO_DATA_BIT    = 3;
	localparam int unsigned PARTIAL_BIT    = 4;
	localparam int unsigned LOW_ADDR_BIT   = 5;
	localparam int unsigned DATA_WALK_BIT  = 0;
	localparam int unsigned INSTR_WALK_BIT = 1;

	// ----------------------------------------
	// select control slots, a then b of each pair
	// ----------------------------------------
	localparam int unsigned IDX_SPLIT = 0;
	localparam int unsigned IDX_ORDER = 2;
	localparam int unsigned IDX_WALK  = 4;
	localparam int unsigned IDX_BUS   = 6;

	// counter slots 0..3 are counters 0..3, slots 4..7 are counters 8..11
	localparam int unsigned SLOT_HIGH = 4;
	localparam int unsigned SLOT_RET  = 6;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_SEL_BASE = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_CFG_BASE = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_CNT_BASE = 12'h040;

endpackage : replay_event_pkg

// file: hw/event_qualifier.sv
// one select control matched against one event source
`timescale 1ns/1ps
`default_nettype none

module event_qualifier
	import replay_event_pkg::*;
(
	input  wire logic [DATA_W-1:0]  ctl,
	input  wire logic [CODE_W-1:0]  code,
	input  wire logic [CAUSE_W-1:0] causes,
	output logic                    hit
);

	// ----------------------------------------
	// field extraction
	// ----------------------------------------
	wire [CODE_W-1:0]  sel_code;
	wire [CAUSE_W-1:0] sel_mask;
	wire               code_ok;
	wire               cause_ok;

	assign sel_code = ctl[CODE_HI:CODE_LO];
	assign sel_mask = ctl[MASK_HI:MASK_LO];
	assign code_ok  = (sel_code == code);
	assign cause_ok = |(sel_mask & causes);
	assign hit      = code_ok & cause_ok;

endmodule : event_qualifier
`default_nettype wire

// file: hw/perf_counter.sv
// one loadable event counter
`timescale 1ns/1ps
`default_nettype none

module perf_counter #(
	parameter int unsigned W = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         inc,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic      [W-1:0] count
);

	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;

	// ----------------------------------------
	// software load wins over a count
	// ----------------------------------------
	assign count_nxt = load ? load_val : (inc ? W'(count_r + 1'b1) : count_r);
	assign count     = count_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count_r <= '0;
		else
			count_r <= count_nxt;
	end

endmodule : perf_counter
`default_nettype wire

// file: hw/memory_replay_event_select.sv
// event selection, qualification and counting for memory replay events
//
// Contract
// - count load port replays by cause mask
// - at-retirement port replay only via second control
// - store replay code 05H, bit 1, select 02H
// - port replays on counters 8-9 or 10-11
// - ordering buffer replay code 03H, select 02H
// - mask bits 1, 3: unknown store address, data
// - mask bit 4: partial_overlap_cause overlap
// - mask bit 5: low address bits differ
// - page walks code 01H, select 04H
// - walk bits 0 data miss, 1 instruction miss
// - bus unit cache refs on counters 0-3
// - cache ref mask combines type and result
`timescale 1ns/1ps
`default_nettype none

module memory_replay_event_select #(
	parameter int unsigned CNT_W = 32
) (
	input  wire logic                                  clk,
	input  wire logic                                  rst_n,
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [replay_event_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [replay_event_pkg::DATA_W-1:0]   pwdata,
	output logic      [replay_event_pkg::DATA_W-1:0]   prdata,
	output logic                                       pready,
	output logic                                       pslverr,
	input  wire logic                                  split_load_cause,
	input  wire logic                                  split_store_cause,
	input  wire logic                                  unknown_store_addr_cause,
	input  wire logic                                  unknown_store_data_cause,
	input  wire logic                                  partial_overlap_cause,
	input  wire logic                                  low_addr_mismatch_cause,
	input  wire logic                                  data_xlate_miss_walk,
	input  wire logic                                  instr_xlate_miss_walk,
	input  wire logic [replay_event_pkg::CAUSE_W-1:0]  bus_ref_cause,
	input  wire logic                                  retire_ok,
	output logic      [replay_event_pkg::NUM_SEL-1:0]  event_hit
);
	import replay_event_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [DATA_W-1:0]  sel_r [0:NUM_SEL-1];
	logic [DATA_W-1:0]  cfg_r [0:NUM_CNT-1];
	logic [DATA_W-1:0]  prdata_r;
	logic [DATA_W-1:0]  prdata_nxt;
	logic               pready_r;
	logic               pslverr_r;
	logic [NUM_SEL-1:0] event_hit_r;

	wire [CNT_W-1:0]    cnt_val [0:NUM_CNT-1];
	wire [NUM_CNT-1:0]  cnt_inc;
	wire [NUM_CNT-1:0]  cnt_wr;
	wire [NUM_SEL-1:0]  qhit;
	wire [1:0]          ld_hit;
	wire [1:0]          st_hit;

	// ----------------------------------------
	// cause vectors in mask bit order
	// ----------------------------------------
	wire [CAUSE_W-1:0] load_vec;
	wire [CAUSE_W-1:0] store_vec;
	wire [CAUSE_W-1:0] order_vec;
	wire [CAUSE_W-1:0] walk_vec;

	assign load_vec  = CAUSE_W'(split_load_cause) << SPLIT_BIT;
	assign store_vec = CAUSE_W'(split_store_cause) << SPLIT_BIT;
	assign order_vec = (CAUSE_W'(unknown_store_addr_cause) << NO_ADDR_BIT)
	                 | (CAUSE_W'(unknown_store_data_cause) << NO_DATA_BIT)
	                 | (CAUSE_W'(partial_overlap_cause) << PARTIAL_BIT)
	                 | (CAUSE_W'(low_addr_mismatch_cause) << LOW_ADDR_BIT);
	assign walk_vec  = (CAUSE_W'(data_xlate_miss_walk) << DATA_WALK_BIT)
	                 | (CAUSE_W'(instr_xlate_miss_walk) << INSTR_WALK_BIT);

	// ----------------------------------------
	// qualifiers, one set per control of a pair
	// ----------------------------------------
	genvar j;
	generate
		for (j = 0; j < 2; j = j + 1)
		begin : g_pair
			event_qualifier u_load (
				.ctl    (sel_r[IDX_SPLIT + j]),
				.code   (CODE_LOAD_REPLAY),
				.causes (load_vec),
				.hit    (ld_hit[j])
			);
			event_qualifier u_store (
				.ctl    (sel_r[IDX_SPLIT + j]),
				.code   (CODE_STORE_REPLAY),
				.causes (store_vec),
				.hit    (st_hit[j])
			);
			event_qualifier u_order (
				.ctl    (sel_r[IDX_ORDER + j]),
				.code   (CODE_ORDER_REPLAY),
				.causes (order_vec),
				.hit    (qhit[IDX_ORDER + j])
			);
			event_qualifier u_walk (
				.ctl    (sel_r[IDX_WALK + j]),
				.code   (CODE_WALK),
				.causes (walk_vec),
				.hit    (qhit[IDX_WALK + j])
			);
			event_qualifier u_bus (
				.ctl    (sel_r[IDX_BUS + j]),
				.code   (CODE_BUS_REF),
				.causes (bus_ref_cause),
				.hit    (qhit[IDX_BUS + j])
			);
			assign qhit[IDX_SPLIT + j] = ld_hit[j] | st_hit[j];
		end
	endgenerate

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire [IDX_W-1:0] reg_idx;
	wire             setup;
	wire             commit;
	wire             is_sel;
	wire             is_cfg;
	wire             is_cnt;
	wire             addr_ok;
	wire             wr_commit;
	wire [DATA_W-1:0] rd_mux;

	assign reg_idx   = paddr[IDX_W+1:2];
	assign setup     = psel & ~penable;
	assign commit    = psel & penable & pready_r;
	assign is_sel    = (paddr[ADDR_W-1:5] == OFS_SEL_BASE[ADDR_W-1:5]);
	assign is_cfg    = (paddr[ADDR_W-1:5] == OFS_CFG_BASE[ADDR_W-1:5]);
	assign is_cnt    = (paddr[ADDR_W-1:5] == OFS_CNT_BASE[ADDR_W-1:5]);
	assign addr_ok   = (is_sel | is_cfg | is_cnt) & (paddr[1:0] == 2'h0);
	assign wr_commit = commit & pwrite & addr_ok;
	assign rd_mux    = is_sel ? (sel_r[reg_idx] & SEL_READ_MASK)
	                 : is_cfg ? (cfg_r[reg_idx] & CFG_READ_MASK)
	                 : is_cnt ? DATA_W'(cnt_val[reg_idx])
	                 : '0;
	assign prdata_nxt = (setup & ~pwrite & addr_ok) ? rd_mux : prdata_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= '0;
		end
		else
		begin
			pready_r  <= setup;
			pslverr_r <= setup & ~addr_ok;
			prdata_r  <= prdata_nxt;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int k = 0; k < NUM_SEL; k++)
				sel_r[k] <= SEL_RST;
			for (int k = 0; k < NUM_CNT; k++)
				cfg_r[k] <= CFG_RST;
		end
		else if (wr_commit & is_sel)
			sel_r[reg_idx] <= pwdata;
		else if (wr_commit & is_cfg)
			cfg_r[reg_idx] <= pwdata;
	end

	// ----------------------------------------
	// counter routing
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < NUM_CNT; i = i + 1)
		begin : g_cnt
			localparam int unsigned PAIR = (i < SLOT_HIGH) ? (i / 2) : ((i - SLOT_HIGH) / 2);
			wire [CSEL_W-1:0] csel;
			wire              src;
			wire              ret_ok;

			assign csel = cfg_r[i][CFG_SEL_HI:CFG_SEL_LO];
			if (i < SLOT_HIGH)
			begin : g_low
				assign src = ((csel == CSEL_ORDER) & qhit[IDX_ORDER + PAIR])
				           | ((csel == CSEL_WALK) & qhit[IDX_WALK + PAIR])
				           | ((csel == CSEL_BUS) & qhit[IDX_BUS + PAIR]);
			end
			else
			begin : g_high
				assign src = (csel == CSEL_SPLIT) & qhit[IDX_SPLIT + PAIR];
			end
			// at-retirement counting only on the second split control
			assign ret_ok = ~cfg_r[i][CFG_RET_BIT] | ((i >= SLOT_RET) & retire_ok);
			assign cnt_inc[i] = cfg_r[i][CFG_EN_BIT] & src & ret_ok;
			assign cnt_wr[i]  = wr_commit & is_cnt & (reg_idx == IDX_W'(i));

			perf_counter #(
				.W (CNT_W)
			) u_cnt (
				.clk      (clk),
				.rst_n    (rst_n),
				.inc      (cnt_inc[i]),
				.load     (cnt_wr[i]),
				.load_val (pwdata[CNT_W-1:0]),
				.count    (cnt_val[i])
			);
		end
	endgenerate

	// ----------------------------------------
	// event outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			event_hit_r <= '0;
		else
			event_hit_r <= qhit;
	end

	assign event_hit = event_hit_r;
	assign prdata    = prdata_r;
	assign pready    = pready_r;
	assign pslverr   = pslverr_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_load_split_hit: assert property (
		(sel_r[IDX_SPLIT][CODE_HI:CODE_LO] == CODE_LOAD_REPLAY) && sel_r[IDX_SPLIT][MASK_LO + SPLIT_BIT]
		&& split_load_cause && !wr_commit |=> event_hit[IDX_SPLIT])
		else $error("load split replay not flagged");

	a_store_split_hit: assert property (
		(sel_r[IDX_SPLIT + 1][CODE_HI:CODE_LO] == CODE_STORE_REPLAY)
		&& sel_r[IDX_SPLIT + 1][MASK_LO + SPLIT_BIT] && split_store_cause |=> event_hit[IDX_SPLIT + 1])
		else $error("store split replay not flagged");

	a_order_addr_hit: assert property (
		(sel_r[IDX_ORDER][CODE_HI:CODE_LO] == CODE_ORDER_REPLAY) && sel_r[IDX_ORDER][MASK_LO + NO_ADDR_BIT]
		&& unknown_store_addr_cause |=> event_hit[IDX_ORDER])
		else $error("unknown store address replay not flagged");

	a_order_partial_hit: assert property (
		(sel_r[IDX_ORDER + 1][CODE_HI:CODE_LO] == CODE_ORDER_REPLAY)
		&& sel_r[IDX_ORDER + 1][MASK_LO + PARTIAL_BIT] && partial_overlap_cause |=> event_hit[IDX_ORDER + 1])
		else $error("partial overlap replay not flagged");

	a_order_lowaddr_hit: assert property (
		(sel_r[IDX_ORDER][CODE_HI:CODE_LO] == CODE_ORDER_REPLAY) && sel_r[IDX_ORDER][MASK_LO + LOW_ADDR_BIT]
		&& low_addr_mismatch_cause |=> event_hit[IDX_ORDER])
		else $error("low address mismatch replay not flagged");

	a_walk_instr_hit: assert property (
		(sel_r[IDX_WALK][CODE_HI:CODE_LO] == CODE_WALK) && sel_r[IDX_WALK][MASK_LO + INSTR_WALK_BIT]
		&& instr_xlate_miss_walk |=> event_hit[IDX_WALK])
		else $error("instruction walk not flagged");

	a_code_mismatch_quiet: assert property (
		(sel_r[IDX_BUS][CODE_HI:CODE_LO] != CODE_BUS_REF) |=> !event_hit[IDX_BUS])
		else $error("bus ref flagged with wrong code");

	a_first_retire_refused: assert property (
		cfg_r[SLOT_HIGH][CFG_RET_BIT] && !cnt_wr[SLOT_HIGH] |=> $stable(cnt_val[SLOT_HIGH]))
		else $error("first split control counted at retirement");

	a_high_counter_source: assert property (
		!qhit[IDX_SPLIT] && !cnt_wr[SLOT_HIGH] |=> $stable(cnt_val[SLOT_HIGH]))
		else $error("counter 8 moved without split control a event");

	a_order_counts_one: assert property (
		(cfg_r[0][CFG_SEL_HI:CFG_SEL_LO] == CSEL_ORDER) && cfg_r[0][CFG_EN_BIT] && !cfg_r[0][CFG_RET_BIT]
		&& qhit[IDX_ORDER] && !cnt_wr[0] |=> (cnt_val[0] == CNT_W'($past(cnt_val[0]) + 1'b1)))
		else $error("counter 0 missed an ordering buffer replay");

	a_walk_counter_b: assert property (
		(cfg_r[2][CFG_SEL_HI:CFG_SEL_LO] == CSEL_WALK) && cfg_r[2][CFG_EN_BIT] && !cfg_r[2][CFG_RET_BIT]
		&& qhit[IDX_WALK + 1] && !cnt_wr[2] |=> (cnt_val[2] == CNT_W'($past(cnt_val[2]) + 1'b1)))
		else $error("counter 2 missed a page walk");

	a_bus_counter_a: assert property (
		(cfg_r[1][CFG_SEL_HI:CFG_SEL_LO] == CSEL_BUS) && cfg_r[1][CFG_EN_BIT] && !cfg_r[1][CFG_RET_BIT]
		&& qhit[IDX_BUS] && !cnt_wr[1] |=> (cnt_val[1] == CNT_W'($past(cnt_val[1]) + 1'b1)))
		else $error("counter 1 missed a cache reference");

	a_apb_one_wait: assert property (
		psel && !penable |=> pready)
		else $error("pready not high in access phase");

endmodule : memory_replay_event_select
`default_nettype wire

// file: tb/event_source_model.sv
// event source model standing in for the memory pipeline and bus unit
`timescale 1ns/1ps
`default_nettype none

module event_source_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        go,
	input  wire logic [7:0]  pat,
	input  wire logic [15:0] bus_pat,
	output logic      [7:0]  causes,
	output logic      [15:0] bus_causes
);
	// ----------------------------------------
	// one-cycle cause pulses, quiet otherwise
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			causes     <= 8'h00;
			bus_causes <= 16'h0000;
		end
		else
		begin
			causes     <= go ? pat : 8'h00;
			bus_causes <= go ? bus_pat : 16'h0000;
		end
	end
endmodule : event_source_model
`default_nettype wire

// file: tb/memory_replay_event_select_bench.sv
// self-checking bench for the memory replay event selection block
`timescale 1ns/1ps
`default_nettype none

module memory_replay_event_select_bench;
	import replay_event_pkg::*;
	logic               clk, rst_n, psel, penable, pwrite, pready, pslverr, go, retire_ok;
	logic [ADDR_W-1:0]  paddr;
	logic [DATA_W-1:0]  pwdata, prdata, rnd;
	logic [NUM_SEL-1:0] event_hit;
	logic [7:0]         pat, cz;
	logic [15:0]        bus_pat, bz;
	logic [33:0]        apb_q[$];
	logic [7:0]         hit_q[$];
	int                 err_count, checks_done;

	// ----------------------------------------
	// design and event source model
	// ----------------------------------------
	memory_replay_event_select i_memory_replay_event_select (
		.clk                      (clk),
		.rst_n                    (rst_n),
		.psel                     (psel),
		.penable                  (penable),
		.pwrite                   (pwrite),
		.paddr                    (paddr),
		.pwdata                   (pwdata),
		.prdata                   (prdata),
		.pready                   (pready),
		.pslverr                  (pslverr),
		.split_load_cause         (cz[0]),
		.split_store_cause        (cz[1]),
		.unknown_store_addr_cause (cz[2]),
		.unknown_store_data_cause (cz[3]),
		.partial_overlap_cause    (cz[4]),
		.low_addr_mismatch_cause  (cz[5]),
		.data_xlate_miss_walk     (cz[6]),
		.instr_xlate_miss_walk    (cz[7]),
		.bus_ref_cause            (bz),
		.retire_ok                (retire_ok),
		.event_hit                (event_hit)
	);
	event_source_model i_event_source_model (
		.clk        (clk),
		.rst_n      (rst_n),
		.go         (go),
		.pat        (pat),
		.bus_pat    (bus_pat),
		.causes     (cz),
		.bus_causes (bz)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic close_out;
		if (apb_q.size() != 0 || hit_q.size() != 0)
			err_count++;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task automatic cmp_apb(input logic [DATA_W-1:0] got, input logic e);
		logic [33:0] x;
		checks_done++;
		x = (apb_q.size() == 0) ? '1 : apb_q.pop_front();
		if (e !== x[32] || (x[33] && got !== x[31:0]))
		begin
			err_count++;
			$display("mismatch at %0t: got %h %h expected %h %h", $time, e, got, x[32], x[31:0]);
		end
	endtask : cmp_apb

	task automatic cmp_hit(input logic [7:0] got);
		logic [7:0] x;
		checks_done++;
		x = (hit_q.size() == 0) ? 8'h00 : hit_q.pop_front();
		if (got !== x)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, x);
		end
	endtask : cmp_hit

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic err, input logic [DATA_W-1:0] exp);
		int n;
		apb_q.push_back({!wr && !err, err, exp});
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			err_count++;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic fire(input logic [7:0] p, input logic [15:0] b, input logic r, input logic [7:0] e);
		if (e !== 8'h00)
			hit_q.push_back(e);
		go        <= 1'b1;
		pat       <= p;
		bus_pat   <= b;
		retire_ok <= r;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
	endtask : fire

	task automatic hit_case(input int k, input logic [CODE_W-1:0] c, input logic [15:0] m,
		input logic [7:0] p, input logic [15:0] b, input logic h);
		apb(1'b1, OFS_SEL_BASE + 12'(4 * k), {c, m, 9'h000}, 1'b0, '0);
		fire(p, b, 1'b0, h ? 8'(1 << k) : 8'h00);
		apb(1'b1, OFS_SEL_BASE + 12'(4 * k), 32'h0000_0000, 1'b0, '0);
	endtask : hit_case

	// ----------------------------------------
	// clock, watchdog, result monitor
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		#100000;
		err_count++;
		close_out();
	end

	always @(posedge clk)
	begin
		if (rst_n === 1'b1 && psel && penable && pready === 1'b1)
			cmp_apb(prdata, pslverr);
		if (rst_n === 1'b1 && event_hit !== 8'h00)
			cmp_hit(event_hit);
	end

	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial
	begin
		int n;
		{rst_n, psel, penable, pwrite, go, retire_ok} = '0;
		{paddr, pwdata, pat, bus_pat} = '0;
		rnd = 32'hBF5DE0EB;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, OFS_SEL_BASE, '0, 1'b0, SEL_RST);
		apb(1'b0, OFS_CFG_BASE, '0, 1'b0, CFG_RST);
		apb(1'b0, OFS_CNT_BASE, '0, 1'b0, 32'h0000_0000);
		for (int k = 0; k < 8; k++)
		begin
			apb(1'b1, OFS_SEL_BASE + 12'(4 * k), '1, 1'b0, '0);
			apb(1'b0, OFS_SEL_BASE + 12'(4 * k), '0, 1'b0, SEL_READ_MASK);
			apb(1'b1, OFS_SEL_BASE + 12'(4 * k), '0, 1'b0, '0);
		end
		apb(1'b1, OFS_CFG_BASE + 12'h00C, '1, 1'b0, '0);
		apb(1'b0, OFS_CFG_BASE + 12'h00C, '0, 1'b0, CFG_READ_MASK);
		apb(1'b1, OFS_CFG_BASE + 12'h00C, '0, 1'b0, '0);
		apb(1'b0, 12'h100, '0, 1'b1, '0);
		apb(1'b1, 12'h002, '1, 1'b1, '0);
		apb(1'b0, OFS_SEL_BASE, '0, 1'b0, 32'h0000_0000);
		hit_case(0, CODE_LOAD_REPLAY, 16'h0002, 8'h01, '0, 1'b1);
		hit_case(1, CODE_STORE_REPLAY, 16'h0002, 8'h02, '0, 1'b1);
		hit_case(0, CODE_STORE_REPLAY, 16'h0002, 8'h01, '0, 1'b0);
		hit_case(2, CODE_ORDER_REPLAY, 16'h0002, 8'h04, '0, 1'b1);
		hit_case(3, CODE_ORDER_REPLAY, 16'h0008, 8'h08, '0, 1'b1);
		hit_case(2, CODE_ORDER_REPLAY, 16'h0010, 8'h10, '0, 1'b1);
		hit_case(3, CODE_ORDER_REPLAY, 16'h0020, 8'h20, '0, 1'b1);
		hit_case(2, CODE_ORDER_REPLAY, 16'h0020, 8'h10, '0, 1'b0);
		hit_case(4, CODE_WALK, 16'h0001, 8'h40, '0, 1'b1);
		hit_case(5, CODE_WALK, 16'h0002, 8'h80, '0, 1'b1);
		hit_case(4, CODE_ORDER_REPLAY, 16'h0001, 8'h40, '0, 1'b0);
		for (int i = 0; i < 6; i++)
		begin
			rnd = lfsr(rnd);
			hit_case(6 + i % 2, CODE_BUS_REF, rnd[31:16], 8'h00, 16'(1 << rnd[3:0]), rnd[16 + rnd[3:0]]);
		end
		apb(1'b1, OFS_CFG_BASE, 32'h0000_5000, 1'b0, '0);
		apb(1'b1, OFS_CFG_BASE + 12'h008, 32'h0000_5000, 1'b0, '0);
		apb(1'b1, OFS_CFG_BASE + 12'h010, 32'h0000_5000, 1'b0, '0);
		apb(1'b1, OFS_CFG_BASE + 12'h018, 32'h0000_5800, 1'b0, '0);
		apb(1'b1, OFS_SEL_BASE, {CODE_LOAD_REPLAY, 16'h0002, 9'h000}, 1'b0, '0);
		apb(1'b1, OFS_SEL_BASE + 12'h004, {CODE_LOAD_REPLAY, 16'h0002, 9'h000}, 1'b0, '0);
		apb(1'b1, OFS_SEL_BASE + 12'h008, {CODE_ORDER_REPLAY, 16'h0002, 9'h000}, 1'b0, '0);
		rnd = lfsr(rnd);
		n = int'(rnd[2:0]) + 1;
		for (int i = 0; i < n; i++)
			fire(8'h05, '0, i[0], 8'h07);
		apb(1'b0, OFS_CNT_BASE, '0, 1'b0, 32'(n));
		apb(1'b0, OFS_CNT_BASE + 12'h008, '0, 1'b0, 32'h0000_0000);
		apb(1'b0, OFS_CNT_BASE + 12'h010, '0, 1'b0, 32'(n));
		apb(1'b0, OFS_CNT_BASE + 12'h014, '0, 1'b0, 32'h0000_0000);
		apb(1'b0, OFS_CNT_BASE + 12'h018, '0, 1'b0, 32'(n / 2));
		rnd = lfsr(rnd);
		apb(1'b1, OFS_CNT_BASE + 12'h004, rnd, 1'b0, '0);
		apb(1'b0, OFS_CNT_BASE + 12'h004, '0, 1'b0, rnd);
		// ----------------------------------------
		// walk and bus routing, retirement on first control
		// ----------------------------------------
		apb(1'b1, OFS_CFG_BASE + 12'h004, 32'h0000_F000, 1'b0, '0);
		apb(1'b1, OFS_CFG_BASE + 12'h008, 32'h0000_9000, 1'b0, '0);
		apb(1'b1, OFS_CFG_BASE + 12'h010, 32'h0000_5800, 1'b0, '0);
		apb(1'b1, OFS_SEL_BASE + 12'h014, {CODE_WALK, 16'h0001, 9'h000}, 1'b0, '0);
		apb(1'b1, OFS_SEL_BASE + 12'h018, {CODE_BUS_REF, 16'h0001, 9'h000}, 1'b0, '0);
		fire(8'h41, 16'h0001, 1'b1, 8'h63);
		apb(1'b0, OFS_CNT_BASE + 12'h004, '0, 1'b0, rnd + 32'h0000_0001);
		apb(1'b0, OFS_CNT_BASE + 12'h008, '0, 1'b0, 32'h0000_0001);
		apb(1'b0, OFS_CNT_BASE + 12'h010, '0, 1'b0, 32'(n));
		apb(1'b0, OFS_CNT_BASE + 12'h018, '0, 1'b0, 32'(n / 2 + 1));
		repeat (4) @(posedge clk);
		close_out();
	end
endmodule : memory_replay_event_select_bench
`default_nettype wire
